// ==== sldc_host.sv ====
// host model driving the serial link of the digit controller
module sldc_host (
  input  wire logic mclk_i,
  input  wire logic dout_i,
  output logic      sclk_o,
  output logic      din_o,
  output logic      load_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // link state
  // cascade samples, one per bit, oldest in the high bits
  logic [15:0] seen;
  initial begin
    sclk_o = 1'b0;
    din_o  = 1'b0;
    load_o = 1'b0;
    seen   = 16'h0000;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // ==========================================
  // one word: msb first, 800 ns serial period, clock idles low
  task automatic send(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      din_o  = w[i];
      sclk_o = 1'b0;
      wait_clk(4);
      sclk_o = 1'b1;
      wait_clk(4);
      // end of high phase: the previous fall has surely reached the pin
      seen = {seen[14:0], dout_i};
    end
    sclk_o = 1'b0;
    // released data line shows the inverse so a stale bit cannot pass
    din_o  = ~w[0];
    wait_clk(4);
    load_o = 1'b1;
    wait_clk(5);
    load_o = 1'b0;
    wait_clk(5);
  endtask
endmodule

// ==== sldc_link.sv ====
// serial front end: pin sync, shift register, cascade out
module sldc_link (
  input  wire logic  mclk_i,
  input  wire logic  rst_b_i,
  input  wire logic  ce_i,
  input  wire logic  sclk_i,
  input  wire logic  din_i,
  input  wire logic  load_i,
  output logic       dout_o,
  sldc_link_if.src   link
);
  // ==========================================
  // synchronisers
  logic [1:0]  sclk_m;
  logic [1:0]  load_m;
  logic [1:0]  din_m;
  logic        sclk_d;
  logic        load_d;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        load_rise;
  logic [15:0] shreg;
  logic        spill;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_m <= 2'h0;
      load_m <= 2'h0;
      din_m  <= 2'h0;
      sclk_d <= 1'b0;
      load_d <= 1'b0;
    end else if (ce_i) begin
      sclk_m <= {sclk_m[0], sclk_i};
      load_m <= {load_m[0], load_i};
      din_m  <= {din_m[0], din_i};
      sclk_d <= sclk_m[1];
      load_d <= load_m[1];
    end
  end

  assign sclk_rise = sclk_m[1] & ~sclk_d;
  assign sclk_fall = ~sclk_m[1] & sclk_d;
  assign load_rise = load_m[1] & ~load_d;

  // ==========================================
  // shift register, msb first
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shreg <= 16'h0000;
      spill <= 1'b0;
    end else if (ce_i && sclk_rise) begin
      shreg <= {shreg[14:0], din_m[1]};
      // the msb pushed out here is what leaves on the next fall
      spill <= shreg[15];
    end
  end

  // a bit leaves on the fall after the rise that pushes it out: 16.5 link clocks
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dout_o <= 1'b0;
    end else if (ce_i && sclk_fall) begin
      dout_o <= spill;
    end
  end

  // ==========================================
  // word handover on load rise
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link.load_pulse <= 1'b0;
      link.word       <= 16'h0000;
    end else if (ce_i) begin
      link.load_pulse <= load_rise;
      if (load_rise) begin
        link.word <= shreg;
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  shift_in_a: assert property ((ce_i && sclk_rise) |=>
    shreg == 16'({$past(shreg), $past(din_m[1])}))
    else $error("shift register did not take the data bit");
  dout_fall_a: assert property ((ce_i && sclk_fall) |=>
    dout_o == $past(spill))
    else $error("cascade output not updated on falling edge");
endmodule

// ==== sldc_link_if.sv ====
// carrier for latched words from the serial front end
interface sldc_link_if;
  logic [15:0] word;
  logic        load_pulse;
  modport src (output word, output load_pulse);
  modport dst (input word, input load_pulse);
endinterface

// ==== sldc_pkg.sv ====
// constants shared by the serial LED digit controller
package sldc_pkg;
  // ==========================================
  // serial word layout
  localparam int WORD_BITS = 16;
  localparam int ADDR_HI   = 11;
  localparam int ADDR_LO   = 8;
  localparam int DATA_HI   = 7;
  localparam int DIGITS    = 4;
  // ==========================================
  // register addresses
  localparam logic [3:0] ADDR_NOOP   = 4'h0;
  localparam logic [3:0] ADDR_DGT_LO = 4'h1;
  localparam logic [3:0] ADDR_DGT_HI = 4'h4;
  localparam logic [3:0] ADDR_DECODE = 4'h9;
  localparam logic [3:0] ADDR_BRIGHT = 4'ha;
  localparam logic [3:0] ADDR_SCAN   = 4'hb;
  localparam logic [3:0] ADDR_PWRDN  = 4'hc;
  localparam logic [3:0] ADDR_RSTCLK = 4'he;
  localparam logic [3:0] ADDR_TEST   = 4'hf;
  // ==========================================
  // field positions and reset values
  localparam int RUN_BIT    = 0;
  localparam int SWRST_BIT  = 0;
  localparam int EXTCLK_BIT = 1;
  localparam int TEST_BIT   = 0;
  localparam logic [7:0] DIGIT_RST  = 8'h00;
  localparam logic [7:0] DECODE_RST = 8'h00;
  localparam logic [3:0] BRIGHT_RST = 4'h0;
  localparam logic [2:0] SCAN_RST   = 3'h0;
  localparam logic [6:0] SEG_ALL    = 7'h7f;
  localparam logic [3:0] DIG_OFF    = 4'hf;
  // ==========================================
  // timing
  localparam int MCLK_NS   = 100;
  localparam int WAKE_NS   = 250000;
  localparam int SCAN_HZ   = 800;
  localparam int PWM_STEPS = 32;
  localparam int MCLK_HZ   = 1000000000 / MCLK_NS;
  localparam logic [11:0] WAKE_CYC = 12'(WAKE_NS / MCLK_NS);
  localparam logic [6:0] STEP_CYC =
    7'(MCLK_HZ / (SCAN_HZ * DIGITS * PWM_STEPS));
  // ==========================================
  // power state
  typedef enum logic [2:0] {
    PWR_DOWN = 3'b001,
    PWR_WAKE = 3'b010,
    PWR_ON   = 3'b100
  } sldc_pwr_t;
endpackage

// ==== sldc_top.sv ====
// four-digit LED driver register front end, display logic
// ==========================================
// Overview of operation
// - shift one bit per serial rising edge
// - load rise copies word to addressed register
// - cascade output lags 16.5 cycles, falling edges
// - msb first; address D11-D8, data D7-D0
// - eleven registers selected by 4-bit address
// - digit write changes only that digit
// - shutdown blanks segments low, digits high
// - shutdown keeps digit contents
// - leaving shutdown takes 250 us
// - writes accepted in shutdown; test overrides
// - power-up resets registers, blank, shutdown
// - defaults: one digit, no decode, minimum
// - decode register bit per digit enables font
// - undecoded digit drives segments from data
// - D7 drives decimal point, decoded or not
// - font shows 0-9, E, H, L, P, dash
// - shutdown register D0 one means run
// - brightness register gives sixteen duty steps
// - scan limit picks digits from digit 0
// - fixed address map of all registers
module sldc_top (
  input  wire logic  MCLK_I,
  input  wire logic  RST_B_I,
  input  wire logic  CE_I,
  input  wire logic  SCLK_I,
  input  wire logic  DIN_I,
  input  wire logic  LOAD_I,
  output logic       DOUT_O,
  output logic [6:0] SEGMENT_OUTPUTS_O,
  output logic       DECIMAL_POINT_O,
  output logic [3:0] DIGIT_OUTPUTS_O,
  output logic       EXT_CLK_SEL_O
);
  // ==========================================
  // helpers
  function automatic logic [6:0] font(input logic [3:0] code);
    logic [6:0] seg;
    seg = 7'h00;
    unique case (code)
      4'h0: seg = 7'h7e;
      4'h1: seg = 7'h30;
      4'h2: seg = 7'h6d;
      4'h3: seg = 7'h79;
      4'h4: seg = 7'h33;
      4'h5: seg = 7'h5b;
      4'h6: seg = 7'h5f;
      4'h7: seg = 7'h70;
      4'h8: seg = 7'h7f;
      4'h9: seg = 7'h7b;
      4'ha: seg = 7'h01;
      4'hb: seg = 7'h4f;
      4'hc: seg = 7'h37;
      4'hd: seg = 7'h0e;
      4'he: seg = 7'h67;
      4'hf: seg = 7'h00;
    endcase
    return seg;
  endfunction

  // digit lines sink current, so the selected one is low
  function automatic logic [3:0] dig_sel(input logic [1:0] idx);
    return ~(4'h1 << idx);
  endfunction

  // ==========================================
  // serial front end
  sldc_link_if link ();

  sldc_link u_link (
    .mclk_i  (MCLK_I),
    .rst_b_i (RST_B_I),
    .ce_i    (CE_I),
    .sclk_i  (SCLK_I),
    .din_i   (DIN_I),
    .load_i  (LOAD_I),
    .dout_o  (DOUT_O),
    .link    (link.src)
  );

  // ==========================================
  // word decode
  logic [3:0] addr;
  logic [7:0] data;
  logic       wr;
  logic       sw_rst;
  logic       wr_digit;
  logic [1:0] wr_idx;

  assign addr     = link.word[sldc_pkg::ADDR_HI:sldc_pkg::ADDR_LO];
  assign data     = link.word[sldc_pkg::DATA_HI:0];
  assign wr       = link.load_pulse && CE_I;
  assign sw_rst   = wr && addr == sldc_pkg::ADDR_RSTCLK
                    && data[sldc_pkg::SWRST_BIT];
  // no-op and unused codes fall through every store
  assign wr_digit = wr && addr >= sldc_pkg::ADDR_DGT_LO
                    && addr <= sldc_pkg::ADDR_DGT_HI;
  assign wr_idx   = 2'(addr - sldc_pkg::ADDR_DGT_LO);

  // ==========================================
  // digit storage, 4 x 8 bits
  logic [7:0] digit_mem [sldc_pkg::DIGITS];

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < sldc_pkg::DIGITS; i++) begin
        digit_mem[i] <= sldc_pkg::DIGIT_RST;
      end
    end else if (sw_rst) begin
      for (int i = 0; i < sldc_pkg::DIGITS; i++) begin
        digit_mem[i] <= sldc_pkg::DIGIT_RST;
      end
    end else if (wr_digit) begin
      // stored regardless of power state
      digit_mem[wr_idx] <= data;
    end
  end

  // ==========================================
  // control registers
  logic [7:0] digit_decode_enable;
  logic [3:0] bright;
  logic [2:0] scan_lim;
  logic       run;
  logic       test_on;

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      digit_decode_enable <= sldc_pkg::DECODE_RST;
    end else if (sw_rst) begin
      digit_decode_enable <= sldc_pkg::DECODE_RST;
    end else if (wr && addr == sldc_pkg::ADDR_DECODE) begin
      digit_decode_enable <= data;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      bright <= sldc_pkg::BRIGHT_RST;
    end else if (sw_rst) begin
      bright <= sldc_pkg::BRIGHT_RST;
    end else if (wr && addr == sldc_pkg::ADDR_BRIGHT) begin
      bright <= data[3:0];
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      scan_lim <= sldc_pkg::SCAN_RST;
    end else if (sw_rst) begin
      scan_lim <= sldc_pkg::SCAN_RST;
    end else if (wr && addr == sldc_pkg::ADDR_SCAN) begin
      scan_lim <= data[2:0];
    end
  end

  // power_down_control: only D0 is kept
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      run <= 1'b0;
    end else if (sw_rst) begin
      run <= 1'b0;
    end else if (wr && addr == sldc_pkg::ADDR_PWRDN) begin
      run <= data[sldc_pkg::RUN_BIT];
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      test_on <= 1'b0;
    end else if (sw_rst) begin
      test_on <= 1'b0;
    end else if (wr && addr == sldc_pkg::ADDR_TEST) begin
      test_on <= data[sldc_pkg::TEST_BIT];
    end
  end

  // clock select is only reported; the scan always runs on MCLK_I
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      EXT_CLK_SEL_O <= 1'b0;
    end else if (wr && addr == sldc_pkg::ADDR_RSTCLK) begin
      EXT_CLK_SEL_O <= data[sldc_pkg::EXTCLK_BIT];
    end
  end

  // ==========================================
  // power sequencing
  sldc_pkg::sldc_pwr_t pwr;
  sldc_pkg::sldc_pwr_t next_pwr;
  logic [11:0]         wake_cnt;

  always_comb begin
    next_pwr = pwr;
    unique case (pwr)
      sldc_pkg::PWR_DOWN: begin
        if (run) begin
          next_pwr = sldc_pkg::PWR_WAKE;
        end
      end
      sldc_pkg::PWR_WAKE: begin
        if (!run) begin
          next_pwr = sldc_pkg::PWR_DOWN;
        end else if (wake_cnt == sldc_pkg::WAKE_CYC - 12'h001) begin
          next_pwr = sldc_pkg::PWR_ON;
        end
      end
      sldc_pkg::PWR_ON: begin
        if (!run) begin
          next_pwr = sldc_pkg::PWR_DOWN;
        end
      end
      default: next_pwr = sldc_pkg::PWR_DOWN;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pwr <= sldc_pkg::PWR_DOWN;
    end else if (CE_I) begin
      pwr <= next_pwr;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wake_cnt <= 12'h000;
    end else if (CE_I) begin
      if (pwr == sldc_pkg::PWR_WAKE && run) begin
        wake_cnt <= wake_cnt + 12'h001;
      end else begin
        wake_cnt <= 12'h000;
      end
    end
  end

  // ==========================================
  // scan and brightness timing
  logic [6:0] step_cnt;
  logic [4:0] slot;
  logic [1:0] cur_dig;
  logic [1:0] last_dig;
  logic       lit;

  // limits above the last digit clamp to all four
  assign last_dig = test_on ? 2'h3
                  : (scan_lim > 3'h3 ? 2'h3 : scan_lim[1:0]);
  // duty (2k+1)/32 of each digit slot
  assign lit      = slot <= {bright, 1'b0};

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      step_cnt <= 7'h00;
      slot     <= 5'h00;
      cur_dig  <= 2'h0;
    end else if (CE_I) begin
      if (step_cnt == sldc_pkg::STEP_CYC - 7'h01) begin
        step_cnt <= 7'h00;
        slot     <= slot + 5'h01;
        if (slot == 5'h1f) begin
          cur_dig <= (cur_dig >= last_dig) ? 2'h0 : cur_dig + 2'h1;
        end
      end else begin
        step_cnt <= step_cnt + 7'h01;
      end
    end
  end

  // ==========================================
  // segment and digit drive
  logic [6:0] next_seg;
  logic       next_point;
  logic [3:0] next_dig;
  logic [7:0] cur_data;

  assign cur_data = digit_mem[cur_dig];

  always_comb begin
    next_seg = 7'h00;
    next_point = 1'b0;
    next_dig = sldc_pkg::DIG_OFF;
    if (test_on) begin
      // test lights everything even in shutdown
      next_seg = sldc_pkg::SEG_ALL;
      next_point = 1'b1;
      next_dig = dig_sel(cur_dig);
    end else if (pwr == sldc_pkg::PWR_ON && lit) begin
      if (digit_decode_enable[cur_dig]) begin
        next_seg = font(cur_data[3:0]);
      end else begin
        next_seg = cur_data[6:0];
      end
      next_point = cur_data[7];
      next_dig = dig_sel(cur_dig);
    end
  end

  // blank drive in shutdown: segments low, digits high
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      SEGMENT_OUTPUTS_O <= 7'h00;
      DECIMAL_POINT_O   <= 1'b0;
      DIGIT_OUTPUTS_O   <= sldc_pkg::DIG_OFF;
    end else if (CE_I) begin
      SEGMENT_OUTPUTS_O <= next_seg;
      DECIMAL_POINT_O   <= next_point;
      DIGIT_OUTPUTS_O   <= next_dig;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence digit_write_s;
    wr_digit && !sw_rst;
  endsequence

  digit_store_a: assert property (digit_write_s |=>
    digit_mem[$past(wr_idx)] == $past(data))
    else $error("digit write not stored");
  digit_keep_a: assert property ((CE_I && !wr_digit && !sw_rst) |=>
    $stable(digit_mem[0]) && $stable(digit_mem[3]))
    else $error("digit changed without a write");
  noop_quiet_a: assert property ((wr && addr == sldc_pkg::ADDR_NOOP) |=>
    $stable(digit_decode_enable) && $stable(bright) && $stable(run))
    else $error("no-op word changed state");
  run_bit_a: assert property ((wr && addr == sldc_pkg::ADDR_PWRDN) |=>
    run == $past(data[0]))
    else $error("shutdown register D0 not taken");
  blank_down_a: assert property ((CE_I && !test_on
    && pwr != sldc_pkg::PWR_ON) |=>
    SEGMENT_OUTPUTS_O == 7'h00 && DIGIT_OUTPUTS_O == 4'hf && !DECIMAL_POINT_O)
    else $error("display not blank in shutdown");
  wake_time_a: assert property ($rose(pwr == sldc_pkg::PWR_ON) |->
    $past(wake_cnt) == sldc_pkg::WAKE_CYC - 12'h001)
    else $error("display resumed at wrong time");
  test_over_a: assert property ((CE_I && test_on) |=>
    SEGMENT_OUTPUTS_O == 7'h7f && DECIMAL_POINT_O)
    else $error("display test did not override");
  decode_store_a: assert property ((wr && addr == sldc_pkg::ADDR_DECODE
    && !sw_rst) |=> digit_decode_enable == $past(data))
    else $error("decode register not stored");
endmodule

// ==== sldc_top_tb.sv ====
// self-checking bench for the serial LED digit controller
module sldc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // signals
  logic       mclk;
  logic       rst_b;
  logic       sclk;
  logic       din;
  logic       load;
  logic       dout;
  logic [6:0] seg;
  logic       point;
  logic [3:0] dig;
  logic       ext_sel;
  int         miscompares;
  int         n_checks;
  localparam logic [6:0] FONT [16] = '{7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f, 7'h70,
                                       7'h7f, 7'h7b, 7'h01, 7'h4f, 7'h37, 7'h0e, 7'h67, 7'h00};
  sldc_top DUT (
    .MCLK_I            (mclk),
    .RST_B_I           (rst_b),
    .CE_I              (1'b1),
    .SCLK_I            (sclk),
    .DIN_I             (din),
    .LOAD_I            (load),
    .DOUT_O            (dout),
    .SEGMENT_OUTPUTS_O (seg),
    .DECIMAL_POINT_O   (point),
    .DIGIT_OUTPUTS_O   (dig),
    .EXT_CLK_SEL_O     (ext_sel)
  );
  sldc_host host (
    .mclk_i (mclk),
    .dout_i (dout),
    .sclk_o (sclk),
    .din_o  (din),
    .load_o (load)
  );
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // ==========================================
  // shared tasks
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] addr, input logic [7:0] data);
    host.send({4'h0, addr, data});
  endtask
  task automatic wait_dig(input int sel, input logic val);
    int k;
    k = 0;
    while (dig[sel] !== val && k < 8000) begin
      wait_cyc(1);
      k++;
    end
    if (k >= 8000) begin
      check("digit wait", 16'h0000, 16'h0001);
    end
  endtask
  // a full off-then-on pass guarantees the latest write is on display
  task automatic show(input int sel, input logic [6:0] exp_seg, input logic exp_point);
    wait_dig(sel, 1'b1);
    wait_dig(sel, 1'b0);
    wait_cyc(2);
    check("digit select", {12'h000, ~(4'h1 << sel)}, {12'h000, dig});
    check("segments", {9'h000, exp_seg}, {9'h000, seg});
    check("decimal point", {15'h0000, exp_point}, {15'h0000, point});
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    check("reset digits", 16'h000f, {12'h000, dig});
    check("reset segments", 16'h0000, {8'h00, seg, point});
    check("reset cascade", 16'h0000, {15'h0000, dout});
  endtask
  task automatic t_wake;
    wreg(sldc_pkg::ADDR_DGT_LO, 8'h83);
    wreg(sldc_pkg::ADDR_PWRDN, 8'h01);
    wait_cyc(int'(sldc_pkg::WAKE_CYC) - 500);
    check("waking digits", 16'h000f, {12'h000, dig});
    show(0, 7'h03, 1'b1);
  endtask
  task automatic t_cascade;
    host.send(16'hb0c5);
    host.send(16'h0000);
    check("cascade bits", {1'b0, 15'h5862}, {1'b0, host.seen[14:0]});
    show(0, 7'h03, 1'b1);
  endtask
  task automatic t_shutdown;
    wreg(sldc_pkg::ADDR_PWRDN, 8'hfe);
    wait_cyc(200);
    check("down digits", 16'h000f, {12'h000, dig});
    check("down segments", 16'h0000, {8'h00, seg, point});
    wreg(sldc_pkg::ADDR_DECODE, 8'h01);
    wreg(sldc_pkg::ADDR_PWRDN, 8'h01);
    show(0, 7'h79, 1'b1);
  endtask
  task automatic t_two_digits;
    wreg(sldc_pkg::ADDR_SCAN, 8'h01);
    wreg(sldc_pkg::ADDR_DGT_LO + 4'h1, 8'h30);
    show(1, 7'h30, 1'b0);
    show(0, 7'h79, 1'b1);
    wreg(sldc_pkg::ADDR_SCAN, 8'h00);
  endtask
  task automatic t_font;
    for (int i = 0; i < 16; i++) begin
      wreg(sldc_pkg::ADDR_DGT_LO, {i[0], 3'h5, i[3:0]});
      show(0, FONT[i], i[0]);
    end
  endtask
  // lit run of digit 0 is 2k+1 scan steps; the upper nibble must not count
  task automatic t_bright;
    int n;
    n = 0;
    wreg(sldc_pkg::ADDR_BRIGHT, 8'hf1);
    wait_dig(0, 1'b1);
    wait_dig(0, 1'b0);
    while (dig[0] === 1'b0 && n < 8000) begin
      wait_cyc(1);
      n++;
    end
    check("lit steps", 16'(3 * int'(sldc_pkg::STEP_CYC)), 16'(n));
  endtask
  task automatic t_ext_clock;
    wreg(4'h5, 8'h12);
    wreg(sldc_pkg::ADDR_RSTCLK, 8'h02);
    wait_cyc(10);
    check("ext clock select", 16'h0001, {15'h0000, ext_sel});
    show(0, FONT[15], 1'b1);
    wreg(sldc_pkg::ADDR_RSTCLK, 8'h03);
    wait_cyc(4);
    check("soft reset digits", 16'h000f, {12'h000, dig});
    check("soft reset clock select", 16'h0001, {15'h0000, ext_sel});
  endtask
  // test must light the display although the soft reset left it shut down
  task automatic t_test;
    wreg(sldc_pkg::ADDR_TEST, 8'h01);
    check("test segments", 16'h00ff, {8'h00, seg, point});
    check("test digit lines", 16'h0001, 16'($countones(~dig)));
    wreg(sldc_pkg::ADDR_TEST, 8'h00);
    check("test off digits", 16'h000f, {12'h000, dig});
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    miscompares = 0;
    n_checks    = 0;
    rst_b       = 1'b0;
    wait_cyc(8);
    t_reset();
    rst_b = 1'b1;
    wait_cyc(4);
    t_wake();
    t_cascade();
    t_shutdown();
    t_two_digits();
    t_font();
    t_bright();
    t_ext_clock();
    t_test();
    tally_and_finish();
  end
  initial begin
    repeat (98000) @(posedge mclk);
    miscompares++;
    tally_and_finish();
  end
endmodule
